// ==== src/siosel_brake_timer.sv ====
// Brake hold timer: counts load_val steps of STEP_CYC clock cycles.
// Assumes start is a one-cycle pulse from the core; abort is a level held while the drive is enabled.
`timescale 1ns/10ps
module siosel_brake_timer #(
    parameter int STEP_CYC = siosel_pkg::BRAKE_STEP_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Core side
    siosel_brk_if.timer brk
);
    localparam int PW = $clog2(STEP_CYC + 1);
    localparam logic [PW-1:0] PRE_TOP = PW'(STEP_CYC - 1);

    logic [PW-1:0] pre_ff;
    logic [PW-1:0] nxt_pre;
    logic [7:0] steps_ff;
    logic [7:0] nxt_steps;

    wire step_end = (pre_ff == '0);
    wire running = (steps_ff != 8'h00);

    // Abort wins, so a servo-on during the hold always keeps the brake free
    assign nxt_steps = brk.abort ? 8'h00 :
                       brk.start ? brk.load_val :
                       (running && step_end) ? steps_ff - 8'h01 : steps_ff;
    assign nxt_pre = (brk.abort || brk.start || step_end) ? PRE_TOP :
                     pre_ff - PW'(1);
    assign brk.busy = running;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pre_ff <= PRE_TOP;
            steps_ff <= 8'h00;
        end else begin
            pre_ff <= nxt_pre;
            steps_ff <= nxt_steps;
        end
    end

    default clocking tcb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    brake_load_a: assert property (
        (brk.start && !brk.abort && brk.load_val != 8'h00) |=> brk.busy)
        else $error("brake timer did not start");

    brake_abort_a: assert property (
        brk.abort |=> !brk.busy)
        else $error("brake timer did not stop on abort");
endmodule

// ==== src/siosel_brk_if.sv ====
// Interface: start/abort/busy handshake between the signal select core
// and its brake hold timer.
// Assumes both ends share sys_clk.
`timescale 1ns/10ps
interface siosel_brk_if;
    logic start;
    logic abort;
    logic [7:0] load_val;
    logic busy;

    modport ctrl (
        output start,
        output abort,
        output load_val,
        input busy
    );

    modport timer (
        input start,
        input abort,
        input load_val,
        output busy
    );
endinterface

// ==== src/siosel_pkg.sv ====
// Package: offsets, field positions, reset values and timing constants
// for the servo I/O signal select block.
// Assumes a 20 MHz system clock and a plain strobe register port.
package siosel_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 50;

    // Brake timing unit: one step of the brake timing settings
    localparam int BRAKE_STEP_NS = 2000000;
    localparam int BRAKE_STEP_CYC = BRAKE_STEP_NS / CLK_PERIOD_NS;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_TRQ_SEL = 8'h04;
    localparam logic [7:0] OFS_GAIN = 8'h08;
    localparam logic [7:0] OFS_REVERSE = 8'h0C;
    localparam logic [7:0] OFS_TLIM_SEL = 8'h10;
    localparam logic [7:0] OFS_BRK_STALL = 8'h14;
    localparam logic [7:0] OFS_BRK_MOTION = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_TRQ_CMD = 8'h20;
    localparam logic [7:0] OFS_CCW_LIM = 8'h24;

    // Field widths
    localparam int MODE_W = 4;
    localparam int SEL_W = 4;
    localparam int GAIN_W = 8;
    localparam int BRK_W = 8;
    localparam int SAMPLE_W = 16;

    // Gain is fixed point with this many fraction bits
    localparam int GAIN_FRAC = 4;

    // Reset values
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [3:0] RST_TRQ_SEL = 4'h0;
    localparam logic [7:0] RST_GAIN = 8'h10;
    localparam logic RST_REVERSE = 1'b0;
    localparam logic [3:0] RST_TLIM_SEL = 4'h0;
    localparam logic [7:0] RST_BRK_STALL = 8'h00;
    localparam logic [7:0] RST_BRK_MOTION = 8'h00;

    // Status register bit positions
    localparam int ST_TRQ_PATH = 0;
    localparam int ST_TRQ_VALID = 1;
    localparam int ST_CCW_VALID = 2;
    localparam int ST_BRAKE_REL = 3;
    localparam int ST_READY = 4;
    localparam int ST_BRK_BUSY = 5;

    // Control mode codes
    typedef enum logic [3:0] {
        SIOSEL_MODE_POS = 4'h0,
        SIOSEL_MODE_VEL = 4'h1,
        SIOSEL_MODE_TRQ = 4'h2,
        SIOSEL_MODE_POS_VEL = 4'h3,
        SIOSEL_MODE_POS_TRQ = 4'h4,
        SIOSEL_MODE_VEL_TRQ = 4'h5
    } siosel_mode_t;

endpackage

// ==== src/siosel_top.sv ====
// Servo I/O signal select: mode-dependent routing of the analog torque
// command input, brake release output and servo-ready output.
// Assumes inputs synchronous to sys_clk and a one-cycle strobe register
// port whose read data stands in the cycle after the read strobe.
//
// Summary of operation
// - With torque command selection at zero the analog input is not used as the torque command.
// - In torque mode, and in position/torque mode with mode_switch_in high, the input is the torque command, scaled by the gain and inverted on request.
// - In velocity/torque mode with mode_switch_in high the input is the torque command with the same gain and polarity, and no offset or filter.
// - The counter-clockwise torque limit is disregarded while the torque limit selection is not zero.
// - In other modes the input becomes a counter-clockwise torque limit driven by positive values.
// - The analog input is taken as a signed 16-bit sample.
// - Brake release is asserted when the brake is to be freed, with hold times set separately for stall and motion.
// - Servo-ready is asserted only with control and main power present and no alarm.
`timescale 1ns/10ps
module siosel_top #(
    parameter int BRAKE_STEP_CYC = siosel_pkg::BRAKE_STEP_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [siosel_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [siosel_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [siosel_pkg::DATA_W-1:0] reg_rdata,
    // Analog command sample and mode switch
    input wire logic [siosel_pkg::SAMPLE_W-1:0] analog_torque_cmd_in,
    input wire logic mode_switch_in,
    // Drive state
    input wire logic ctrl_power_in,
    input wire logic main_power_in,
    input wire logic alarm_in,
    input wire logic servo_on_in,
    input wire logic motor_moving_in,
    // Routed command and limit
    output logic [siosel_pkg::SAMPLE_W-1:0] torque_cmd_out,
    output logic torque_cmd_valid_out,
    output logic [siosel_pkg::SAMPLE_W-1:0] ccw_torque_limit_in,
    output logic ccw_limit_valid_out,
    // Status outputs
    output logic brake_release_out,
    output logic servo_ready_out
);
    localparam logic signed [15:0] S16_MAX = 16'sh7FFF;
    localparam logic signed [15:0] S16_MIN = -16'sh8000;

    // Saturate a wide signed value into 16 bits
    function automatic logic signed [15:0] sat16(
        input logic signed [24:0] v
    );
        logic signed [15:0] r;
        r = v[15:0];
        if (v > 25'(S16_MAX)) begin
            r = S16_MAX;
        end else if (v < 25'(S16_MIN)) begin
            r = S16_MIN;
        end
        return r;
    endfunction

    // Settings registers
    logic [3:0] control_mode_param_ff;
    logic [3:0] torque_cmd_select_param_ff;
    logic [7:0] torque_input_gain_param_ff;
    logic torque_input_reverse_param_ff;
    logic [3:0] torque_limit_select_param_ff;
    logic [7:0] brake_timing_stall_param_ff;
    logic [7:0] brake_timing_motion_param_ff;

    // Datapath and status state
    logic signed [15:0] sample_ff;
    logic [15:0] trq_out_ff;
    logic trq_valid_ff;
    logic [15:0] ccw_out_ff;
    logic ccw_valid_ff;
    logic release_ff;
    logic ready_ff;
    logic servo_en_ff;
    logic [15:0] rdata_ff;

    siosel_brk_if brk();

    siosel_brake_timer #(
        .STEP_CYC(BRAKE_STEP_CYC)
    ) u_brake_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .brk(brk.timer)
    );

    // Register write decode
    wire wr_mode = reg_wr && (reg_addr == siosel_pkg::OFS_MODE);
    wire wr_sel = reg_wr && (reg_addr == siosel_pkg::OFS_TRQ_SEL);
    wire wr_gain = reg_wr && (reg_addr == siosel_pkg::OFS_GAIN);
    wire wr_rev = reg_wr && (reg_addr == siosel_pkg::OFS_REVERSE);
    wire wr_tlim = reg_wr && (reg_addr == siosel_pkg::OFS_TLIM_SEL);
    wire wr_bstall = reg_wr && (reg_addr == siosel_pkg::OFS_BRK_STALL);
    wire wr_bmotion = reg_wr && (reg_addr == siosel_pkg::OFS_BRK_MOTION);

    // Mode decode: the switched modes hand the input to the torque
    // path only while their second (torque) mode is selected
    wire mode_trq = (control_mode_param_ff == 4'(siosel_pkg::SIOSEL_MODE_TRQ));
    wire mode_pos_trq =
        (control_mode_param_ff == 4'(siosel_pkg::SIOSEL_MODE_POS_TRQ));
    wire mode_vel_trq =
        (control_mode_param_ff == 4'(siosel_pkg::SIOSEL_MODE_VEL_TRQ));
    wire torque_path = mode_trq || ((mode_pos_trq || mode_vel_trq) &&
                                    mode_switch_in);
    wire ccw_path = !torque_path;

    // Torque command: gain, then optional reversal, both saturating
    wire signed [24:0] product =
        sample_ff * $signed({1'b0, torque_input_gain_param_ff});
    wire signed [24:0] scaled_wide = product >>> siosel_pkg::GAIN_FRAC;
    wire signed [15:0] scaled = sat16(scaled_wide);
    wire signed [15:0] negated = sat16(-25'(scaled));
    wire signed [15:0] polar =
        torque_input_reverse_param_ff ? negated : scaled;
    // Selection zero drops the input completely
    wire sel_on = (torque_cmd_select_param_ff != 4'h0);
    wire trq_valid = torque_path && sel_on;
    wire [15:0] nxt_trq_out = trq_valid ? 16'(polar) : 16'h0000;

    // CCW limit: only positive values limit; a set selection disables it
    wire ccw_valid =
        ccw_path && (torque_limit_select_param_ff == 4'h0);
    wire sample_pos = !sample_ff[15] && (sample_ff != 16'sh0000);
    wire [15:0] nxt_ccw_out =
        (ccw_valid && sample_pos) ? 16'(sample_ff) : 16'h0000;

    // Servo ready
    wire nxt_ready = ctrl_power_in && main_power_in && !alarm_in;

    // Brake: free while the drive is enabled; on disable hold release
    // for the stall or motion time, chosen from the state at that moment
    wire servo_en = servo_on_in && nxt_ready;
    wire servo_fall = servo_en_ff && !servo_en;
    wire [7:0] hold_val = motor_moving_in ? brake_timing_motion_param_ff :
                          brake_timing_stall_param_ff;
    wire nxt_release = servo_en ? 1'b1 :
                       servo_fall ? (hold_val != 8'h00) :
                       (release_ff && brk.busy);
    assign brk.start = servo_fall;
    assign brk.abort = servo_en;
    assign brk.load_val = hold_val;

    // Read mux
    wire [15:0] status_word = {
        10'h000,
        brk.busy,
        ready_ff,
        release_ff,
        ccw_valid_ff,
        trq_valid_ff,
        torque_path
    };
    wire [15:0] nxt_rdata =
        !reg_rd ? 16'h0000 :
        (reg_addr == siosel_pkg::OFS_MODE) ? {12'h000, control_mode_param_ff} :
        (reg_addr == siosel_pkg::OFS_TRQ_SEL) ?
            {12'h000, torque_cmd_select_param_ff} :
        (reg_addr == siosel_pkg::OFS_GAIN) ?
            {8'h00, torque_input_gain_param_ff} :
        (reg_addr == siosel_pkg::OFS_REVERSE) ?
            {15'h0000, torque_input_reverse_param_ff} :
        (reg_addr == siosel_pkg::OFS_TLIM_SEL) ?
            {12'h000, torque_limit_select_param_ff} :
        (reg_addr == siosel_pkg::OFS_BRK_STALL) ?
            {8'h00, brake_timing_stall_param_ff} :
        (reg_addr == siosel_pkg::OFS_BRK_MOTION) ?
            {8'h00, brake_timing_motion_param_ff} :
        (reg_addr == siosel_pkg::OFS_STATUS) ? status_word :
        (reg_addr == siosel_pkg::OFS_TRQ_CMD) ? trq_out_ff :
        (reg_addr == siosel_pkg::OFS_CCW_LIM) ? ccw_out_ff :
        16'h0000;

    // Settings
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            control_mode_param_ff <= siosel_pkg::RST_MODE;
            torque_cmd_select_param_ff <= siosel_pkg::RST_TRQ_SEL;
            torque_input_gain_param_ff <= siosel_pkg::RST_GAIN;
            torque_input_reverse_param_ff <= siosel_pkg::RST_REVERSE;
        end else begin
            if (wr_mode) control_mode_param_ff <= reg_wdata[3:0];
            if (wr_sel) torque_cmd_select_param_ff <= reg_wdata[3:0];
            if (wr_gain) torque_input_gain_param_ff <= reg_wdata[7:0];
            if (wr_rev) torque_input_reverse_param_ff <= reg_wdata[0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            torque_limit_select_param_ff <= siosel_pkg::RST_TLIM_SEL;
            brake_timing_stall_param_ff <= siosel_pkg::RST_BRK_STALL;
            brake_timing_motion_param_ff <= siosel_pkg::RST_BRK_MOTION;
        end else begin
            if (wr_tlim) torque_limit_select_param_ff <= reg_wdata[3:0];
            if (wr_bstall) brake_timing_stall_param_ff <= reg_wdata[7:0];
            if (wr_bmotion) brake_timing_motion_param_ff <= reg_wdata[7:0];
        end
    end

    // Sample capture and routed outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sample_ff <= 16'sh0000;
            trq_out_ff <= 16'h0000;
            trq_valid_ff <= 1'b0;
            ccw_out_ff <= 16'h0000;
            ccw_valid_ff <= 1'b0;
        end else begin
            sample_ff <= $signed(analog_torque_cmd_in);
            trq_out_ff <= nxt_trq_out;
            trq_valid_ff <= trq_valid;
            ccw_out_ff <= nxt_ccw_out;
            ccw_valid_ff <= ccw_valid;
        end
    end

    // Status and read data
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            release_ff <= 1'b0;
            ready_ff <= 1'b0;
            servo_en_ff <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            release_ff <= nxt_release;
            ready_ff <= nxt_ready;
            servo_en_ff <= servo_en;
            rdata_ff <= nxt_rdata;
        end
    end

    assign torque_cmd_out = trq_out_ff;
    assign torque_cmd_valid_out = trq_valid_ff;
    assign ccw_torque_limit_in = ccw_out_ff;
    assign ccw_limit_valid_out = ccw_valid_ff;
    assign brake_release_out = release_ff;
    assign servo_ready_out = ready_ff;
    assign reg_rdata = rdata_ff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sel_zero_ignore_a: assert property (
        (torque_cmd_select_param_ff == 4'h0) |=>
            (!torque_cmd_valid_out && torque_cmd_out == 16'h0000))
        else $error("torque command passed with selection zero");

    unity_gain_a: assert property (
        (torque_path && sel_on && !torque_input_reverse_param_ff &&
         torque_input_gain_param_ff == 8'h10) |=>
            (torque_cmd_out == 16'($past(sample_ff))))
        else $error("torque command not equal to sample at unity gain");

    reverse_pol_a: assert property (
        (torque_path && sel_on && torque_input_reverse_param_ff &&
         torque_input_gain_param_ff == 8'h10 && sample_ff != S16_MIN) |=>
            (torque_cmd_out == 16'(-$past(sample_ff))))
        else $error("torque command not inverted");

    vel_trq_path_a: assert property (
        (mode_vel_trq && mode_switch_in && sel_on) |=>
            (torque_cmd_valid_out && !ccw_limit_valid_out))
        else $error("velocity/torque mode did not select torque command");

    ccw_disable_a: assert property (
        (torque_limit_select_param_ff != 4'h0) |=>
            (!ccw_limit_valid_out && ccw_torque_limit_in == 16'h0000))
        else $error("ccw limit active with limit selection set");

    ccw_positive_a: assert property (
        (ccw_path && torque_limit_select_param_ff == 4'h0) |=>
            (ccw_limit_valid_out && !torque_cmd_valid_out &&
             ccw_torque_limit_in == ($past(sample_pos) ?
                 16'($past(sample_ff)) : 16'h0000)))
        else $error("ccw limit does not follow positive input");

    sample_sign_a: assert property (
        (analog_torque_cmd_in[15] && mode_trq && sel_on &&
         !torque_input_reverse_param_ff && torque_input_gain_param_ff != 8'h00
         && $stable(torque_input_gain_param_ff)) |=>
            ##1 torque_cmd_out[15])
        else $error("negative sample lost its sign");

    brake_hold_a: assert property (
        (servo_fall && hold_val != 8'h00) |=> brake_release_out[*2])
        else $error("brake release not held after servo off");

    brake_drop_a: assert property (
        (!servo_en && !servo_fall && !brk.busy) |=> !brake_release_out)
        else $error("brake release stayed on with hold time over");

    ready_cond_a: assert property (
        servo_ready_out |->
            $past(ctrl_power_in && main_power_in && !alarm_in))
        else $error("servo ready without power or with alarm");

    cov_torque_cmd_c: cover property (
        torque_cmd_valid_out && torque_cmd_out != 16'h0000);
    cov_ccw_limit_c: cover property (
        ccw_limit_valid_out && ccw_torque_limit_in != 16'h0000);
    cov_brake_hold_c: cover property (
        servo_fall ##1 brake_release_out ##1 brk.busy);
    cov_ready_rise_c: cover property (!servo_ready_out ##1 servo_ready_out);
endmodule

// ==== tb/siosel_host_model.sv ====
// Host controller model: drives the drive-state and analog command lines.
// Assumes the bench asks for levels; they reach the drive one edge later.
`timescale 1ns/10ps
module siosel_host_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Levels asked for by the bench
    input wire logic [15:0] set_sample,
    input wire logic [4:0] set_state,
    input wire logic set_switch,
    // Lines into the drive
    output logic [15:0] analog_torque_cmd_in,
    output logic mode_switch_in,
    output logic ctrl_power_in,
    output logic main_power_in,
    output logic alarm_in,
    output logic servo_on_in,
    output logic motor_moving_in
);
    // Lines change only on edges, as a synchronous host would drive them
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            analog_torque_cmd_in <= 16'h0000;
            mode_switch_in <= 1'b0;
            {motor_moving_in, servo_on_in, alarm_in} <= 3'h0;
            {main_power_in, ctrl_power_in} <= 2'h0;
        end else begin
            analog_torque_cmd_in <= set_sample;
            mode_switch_in <= set_switch;
            {motor_moving_in, servo_on_in, alarm_in} <= set_state[4:2];
            {main_power_in, ctrl_power_in} <= set_state[1:0];
        end
    end
endmodule

// ==== tb/siosel_top_test.sv ====
// Testbench for the servo I/O signal select block.
// Assumes the host model drives the drive-state lines; short brake step.
`timescale 1ns/10ps
module siosel_top_test;
    localparam int STEP = 4;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] set_sample = 16'h0000;
    logic [4:0] set_state = 5'h00;
    logic set_switch = 1'b0;
    wire [15:0] reg_rdata, sample, cmd, ccw;
    wire sw, ctrl, main, alarm, on, moving, cmd_v, ccw_v, brake, ready;
    int n_fail = 0;
    int cmp_count = 0;
    int n;

    always #25 sys_clk = ~sys_clk;

    siosel_top #(.BRAKE_STEP_CYC(STEP)) u_siosel_top (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .analog_torque_cmd_in(sample),
        .mode_switch_in(sw), .ctrl_power_in(ctrl), .main_power_in(main),
        .alarm_in(alarm), .servo_on_in(on), .motor_moving_in(moving),
        .torque_cmd_out(cmd), .torque_cmd_valid_out(cmd_v),
        .ccw_torque_limit_in(ccw), .ccw_limit_valid_out(ccw_v),
        .brake_release_out(brake), .servo_ready_out(ready)
    );

    siosel_host_model u_siosel_host_model (
        .sys_clk(sys_clk), .rst_n(rst_n), .set_sample(set_sample),
        .set_state(set_state), .set_switch(set_switch),
        .analog_torque_cmd_in(sample), .mode_switch_in(sw),
        .ctrl_power_in(ctrl), .main_power_in(main), .alarm_in(alarm),
        .servo_on_in(on), .motor_moving_in(moving)
    );

    task automatic complete_run;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, input logic [15:0] exp,
                      input string what);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask

    // Model edge plus two datapath stages, with margin
    task automatic settle;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    task automatic tq(input logic [3:0] mode, input logic s,
                      input logic [7:0] gain, input logic rev,
                      input logic [15:0] smp, input logic [15:0] e_cmd,
                      input logic [15:0] e_ccw, input logic [1:0] e_v);
        wr(siosel_pkg::OFS_MODE, {12'h000, mode});
        wr(siosel_pkg::OFS_GAIN, {8'h00, gain});
        wr(siosel_pkg::OFS_REVERSE, {15'h0000, rev});
        set_switch <= s;
        set_sample <= smp;
        settle();
        chk("torque_cmd_out", e_cmd, cmd);
        chk("ccw_torque_limit_in", e_ccw, ccw);
        chk("valid pair", {14'h0000, e_v}, {14'h0000, cmd_v, ccw_v});
    endtask

    // Hold time after servo off; lo and hi bound the cycles that should pass
    task automatic brk(input logic mv, input int lo, input int hi);
        set_state <= {mv, 4'b1011};
        settle();
        chk("brake_release_out on", 16'h0001, {15'h0000, brake});
        rd(siosel_pkg::OFS_STATUS, 16'h0018, "status servo on");
        set_state <= {mv, 4'b0011};
        n = 0;
        for (int c = 0; c < 60; c++) begin
            @(posedge sys_clk);
            #1;
            if (brake === 1'b1) n++;
            else break;
        end
        if (n == 60) begin
            n_fail++;
            $display("ERROR brake hold wait expected end seen timeout");
            complete_run();
        end else begin
            cmp_count++;
            if (n < lo || n > hi) begin
                n_fail++;
                $display("ERROR brake hold expected %0d..%0d seen %0d",
                         lo, hi, n);
            end
        end
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(siosel_pkg::OFS_MODE, 16'h0000, "mode reset");
        rd(siosel_pkg::OFS_TRQ_SEL, 16'h0000, "select reset");
        rd(siosel_pkg::OFS_GAIN, 16'h0010, "gain reset");
        rd(siosel_pkg::OFS_REVERSE, 16'h0000, "reverse reset");
        rd(siosel_pkg::OFS_TLIM_SEL, 16'h0000, "limit select reset");
        rd(siosel_pkg::OFS_BRK_STALL, 16'h0000, "stall hold reset");
        rd(siosel_pkg::OFS_BRK_MOTION, 16'h0000, "motion hold reset");
        rd(8'h30, 16'h0000, "unmapped read");
        wr(siosel_pkg::OFS_TRQ_CMD, 16'h1234);
        rd(siosel_pkg::OFS_TRQ_CMD, 16'h0000, "read-only command");
        wr(siosel_pkg::OFS_GAIN, 16'hFFFF);
        rd(siosel_pkg::OFS_GAIN, 16'h00FF, "gain width");
        // Select zero leaves the torque path idle even in torque mode
        tq(4'h2, 1'b0, 8'h10, 1'b0, 16'h0100, 16'h0000, 16'h0000, 2'b00);
        wr(siosel_pkg::OFS_TRQ_SEL, 16'h0001);
        tq(4'h2, 1'b0, 8'h10, 1'b0, 16'h0100, 16'h0100, 16'h0000, 2'b10);
        rd(siosel_pkg::OFS_STATUS, 16'h0003, "status torque");
        rd(siosel_pkg::OFS_TRQ_CMD, 16'h0100, "command readback");
        // Unity gain reversal with a sample that can be negated exactly
        tq(4'h2, 1'b0, 8'h10, 1'b1, 16'h0100,
           16'hFF00, 16'h0000, 2'b10);
        tq(4'h2, 1'b0, 8'h20, 1'b1, 16'h0100, 16'hFE00, 16'h0000, 2'b10);
        tq(4'h4, 1'b1, 8'h10, 1'b0, 16'h8000, 16'h8000, 16'h0000, 2'b10);
        tq(4'h4, 1'b1, 8'h10, 1'b1, 16'h8000, 16'h7FFF, 16'h0000, 2'b10);
        tq(4'h2, 1'b0, 8'h20, 1'b0, 16'h7FFF, 16'h7FFF, 16'h0000, 2'b10);
        tq(4'h5, 1'b1, 8'h08, 1'b0, 16'hFF00, 16'hFF80, 16'h0000, 2'b10);
        tq(4'h5, 1'b1, 8'h08, 1'b1, 16'hFF00, 16'h0080, 16'h0000, 2'b10);
        tq(4'h0, 1'b0, 8'h10, 1'b0, 16'h0200, 16'h0000, 16'h0200, 2'b01);
        rd(siosel_pkg::OFS_STATUS, 16'h0004, "status ccw");
        rd(siosel_pkg::OFS_CCW_LIM, 16'h0200, "ccw readback");
        tq(4'h4, 1'b0, 8'h20, 1'b0, 16'h0300, 16'h0000, 16'h0300, 2'b01);
        tq(4'h5, 1'b0, 8'h10, 1'b0, 16'h0400, 16'h0000, 16'h0400, 2'b01);
        tq(4'h1, 1'b0, 8'h10, 1'b0, 16'hFF00, 16'h0000, 16'h0000, 2'b01);
        wr(siosel_pkg::OFS_TLIM_SEL, 16'h0001);
        tq(4'h0, 1'b0, 8'h10, 1'b0, 16'h0200, 16'h0000, 16'h0000, 2'b00);
        // Every power and alarm combination, servo off
        for (int i = 0; i < 8; i++) begin
            set_state <= {2'b00, i[2:0]};
            settle();
            chk("servo_ready_out", {15'h0000, i[0] & i[1] & ~i[2]},
                {15'h0000, ready});
        end
        brk(1'b0, 0, 3);
        wr(siosel_pkg::OFS_BRK_STALL, 16'h0003);
        wr(siosel_pkg::OFS_BRK_MOTION, 16'h0001);
        brk(1'b0, 3 * STEP, 3 * STEP + 5);
        brk(1'b1, STEP, STEP + 5);
        complete_run();
    end
endmodule
